// ==== design/cfs_sequencer.sv ====
// Purpose: schedules calibration source flashes and the forced digitizer launch
// Assumes: one clock for systime and registers; register port from the cpu bridge
// Notes: one pattern sample per clock; flash lags the detected instant by a fixed pipe
//
// Summary of operation
// - six source enable bits, control bits 5..0
// - three-bit scheduling field, four settings decoded
// - disabled setting never fires any source
// - periodic fires on rising systime bit 26-rate
// - five-bit rate field sets power-of-two period
// - time match fires once on low-word equality
// - match ignores upper sixteen systime bits
// - cpu setting fires on key write only
// - four-bit signed launch offset, minus8 to 7
// - flash fixed; only digitizer launch shifts
// - dark source launches digitizer without pulsers
// - pulser, led and flasher fire together; ladder streams start one cycle later
// - ladder firing streams all 256 pattern entries
// - flash time captured into low/high registers
// - physical flash two cycles after stamp
// - 48-bit systime readable as low/high words
`timescale 1ns/1ps
module cfs_sequencer
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port
  input cfs_pkg::cfs_req_t req,
  output cfs_pkg::cfs_rsp_t rsp,
  // calibration outputs
  output cfs_pkg::cfs_out_t cal
);
  import cfs_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] match;
    logic [47:0] systime;
    logic [47:0] last_time;
    logic armed;
    logic [2:0] prev_mode;
    logic prev_bit;
    logic [CFS_NSRC-1:0] src;
    logic [CFS_PIPE_LEN-1:0] pipe;
    logic ladder_run;
    logic [7:0] ladder_idx;
    logic fe_run;
    logic dig_run;
    cfs_rsp_t rsp;
    cfs_out_t out;
    logic [CFS_PAT_DEPTH-1:0][7:0] pat;
  } cfs_state_t;

  cfs_state_t s_q;
  cfs_state_t s_d;
  logic [2:0] mode;
  logic [4:0] rate;
  logic [3:0] ofs;
  logic [5:0] bit_sel;
  logic cur_bit;
  logic fire;
  logic [CFS_NSRC-1:0] en;
  logic [3:0] launch_tap;

  assign rsp = s_q.rsp;
  assign cal = s_q.out;

  always_comb
  begin
    s_d = s_q;
    en = s_q.ctrl[CFS_EN_LSB +: CFS_NSRC];
    mode = s_q.ctrl[CFS_MODE_LSB +: 3];
    ofs = s_q.ctrl[CFS_OFS_LSB +: 4];
    rate = s_q.ctrl[CFS_RATE_LSB +: 5];
    fire = 1'b0;
    // ----------------------------------------
    // system time
    // ----------------------------------------
    s_d.systime = s_q.systime + 48'h000000000001;
    // ----------------------------------------
    // periodic edge detect
    // ----------------------------------------
    // rates above 26 would select below bit 0; clamp rather than wrap
    if (rate > 5'h1A)
    begin
      bit_sel = 6'h00;
    end
    else
    begin
      bit_sel = CFS_RATE_TOP_BIT - {1'b0, rate};
    end
    cur_bit = s_q.systime[bit_sel];
    s_d.prev_bit = cur_bit;
    // ----------------------------------------
    // scheduling
    // ----------------------------------------
    s_d.prev_mode = mode;
    if (mode == CFS_MODE_MATCH && s_q.prev_mode != CFS_MODE_MATCH)
    begin
      s_d.armed = 1'b1;
    end
    else if (mode != CFS_MODE_MATCH)
    begin
      s_d.armed = 1'b0;
    end
    case (mode)
      CFS_MODE_PERIODIC:
      begin
        fire = cur_bit && !s_q.prev_bit;
      end
      CFS_MODE_MATCH:
      begin
        if (s_q.armed && s_q.match == s_q.systime[31:0])
        begin
          fire = 1'b1;
          s_d.armed = 1'b0;
        end
      end
      CFS_MODE_CPU:
      begin
        fire = req.wr && req.addr == CFS_IDX_CPU && req.wdata[7:0] == CFS_CPU_KEY;
      end
      default:
      begin
        fire = 1'b0;
      end
    endcase
    if (fire && en == '0)
    begin
      fire = 1'b0;
    end
    // ----------------------------------------
    // flash pipeline
    // ----------------------------------------
    // the flash is delayed so that a negative offset can launch before it
    s_d.pipe = {s_q.pipe[CFS_PIPE_LEN-2:0], fire};
    if (fire)
    begin
      s_d.src = en;
      s_d.last_time = s_q.systime + CFS_STAMP_LEAD;
    end
    launch_tap = ofs + 4'h8;
    s_d.out.pulser = s_q.pipe[CFS_FLASH_TAP] && s_q.src[1];
    s_d.out.led = s_q.pipe[CFS_FLASH_TAP] && s_q.src[2];
    s_d.out.flasher = s_q.pipe[CFS_FLASH_TAP] && s_q.src[3];
    s_d.out.digitizer_launch = s_q.pipe[launch_tap];
    // ----------------------------------------
    // ladder streaming
    // ----------------------------------------
    if (s_q.pipe[CFS_FLASH_TAP] && (s_q.src[4] || s_q.src[5]))
    begin
      s_d.ladder_run = 1'b1;
      s_d.ladder_idx = 8'h00;
      s_d.fe_run = s_q.src[4];
      s_d.dig_run = s_q.src[5];
    end
    else if (s_q.ladder_run)
    begin
      s_d.ladder_idx = s_q.ladder_idx + 8'h01;
      if (s_q.ladder_idx == CFS_PAT_LAST)
      begin
        s_d.ladder_run = 1'b0;
      end
    end
    s_d.out.fe_ladder_valid = s_q.ladder_run && s_q.fe_run;
    s_d.out.dig_ladder_valid = s_q.ladder_run && s_q.dig_run;
    s_d.out.ladder_sample = s_q.ladder_run ? s_q.pat[s_q.ladder_idx] : 8'h00;
    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (req.wr)
    begin
      if (req.addr[CFS_PAT_SEL_BIT])
      begin
        s_d.pat[req.addr[7:0]] = req.wdata[7:0];
      end
      else if (req.addr == CFS_IDX_CTRL)
      begin
        s_d.ctrl = req.wdata & CFS_CTRL_MASK;
      end
      else if (req.addr == CFS_IDX_MATCH)
      begin
        s_d.match = req.wdata;
      end
    end
    // ----------------------------------------
    // register reads
    // ----------------------------------------
    s_d.rsp.valid = req.rd;
    s_d.rsp.data = 32'h00000000;
    if (req.rd)
    begin
      if (req.addr[CFS_PAT_SEL_BIT])
      begin
        s_d.rsp.data = {24'h000000, s_q.pat[req.addr[7:0]]};
      end
      else if (req.addr == CFS_IDX_CTRL)
      begin
        s_d.rsp.data = s_q.ctrl;
      end
      else if (req.addr == CFS_IDX_MATCH)
      begin
        s_d.rsp.data = s_q.match;
      end
      else if (req.addr == CFS_IDX_LAST_LO)
      begin
        s_d.rsp.data = s_q.last_time[31:0];
      end
      else if (req.addr == CFS_IDX_LAST_HI)
      begin
        s_d.rsp.data = {16'h0000, s_q.last_time[47:32]};
      end
      else if (req.addr == CFS_IDX_SYS_LO)
      begin
        s_d.rsp.data = s_q.systime[31:0];
      end
      else if (req.addr == CFS_IDX_SYS_HI)
      begin
        s_d.rsp.data = {16'h0000, s_q.systime[47:32]};
      end
      else
      begin
        s_d.rsp.data = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// ==== design/cfs_pkg.sv ====
// Purpose: shared constants and types for the calibration flash sequencer
// Assumes: one 32-bit word per register, word-indexed register port
// Notes: pattern memory sits in the upper half of the index space
package cfs_pkg;
  // ----------------------------------------
  // register index map
  // ----------------------------------------
  localparam int CFS_AW = 9;
  localparam logic [8:0] CFS_IDX_CTRL = 9'h000;
  localparam logic [8:0] CFS_IDX_MATCH = 9'h001;
  localparam logic [8:0] CFS_IDX_CPU = 9'h002;
  localparam logic [8:0] CFS_IDX_LAST_LO = 9'h003;
  localparam logic [8:0] CFS_IDX_LAST_HI = 9'h004;
  localparam logic [8:0] CFS_IDX_SYS_LO = 9'h005;
  localparam logic [8:0] CFS_IDX_SYS_HI = 9'h006;
  localparam int CFS_PAT_SEL_BIT = 8;
  // ----------------------------------------
  // control word fields
  // ----------------------------------------
  localparam int CFS_EN_LSB = 0;
  localparam int CFS_NSRC = 6;
  localparam int CFS_MODE_LSB = 12;
  localparam int CFS_OFS_LSB = 16;
  localparam int CFS_RATE_LSB = 24;
  localparam logic [31:0] CFS_CTRL_MASK = 32'h1F0F703F;
  localparam logic [31:0] CFS_CTRL_RESET = 32'h00000000;
  localparam logic [2:0] CFS_MODE_OFF = 3'h0;
  localparam logic [2:0] CFS_MODE_PERIODIC = 3'h1;
  localparam logic [2:0] CFS_MODE_MATCH = 3'h2;
  localparam logic [2:0] CFS_MODE_CPU = 3'h3;
  localparam logic [7:0] CFS_CPU_KEY = 8'hA5;
  localparam logic [5:0] CFS_RATE_TOP_BIT = 6'h1A;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CFS_PIPE_LEN = 16;
  localparam int CFS_FLASH_TAP = 8;
  localparam logic [47:0] CFS_STAMP_LEAD = 48'h000000000008;
  localparam int CFS_PAT_DEPTH = 256;
  localparam logic [7:0] CFS_PAT_LAST = 8'hFF;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [31:0] wdata;
  } cfs_req_t;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } cfs_rsp_t;
  typedef struct packed {
    logic pulser;
    logic led;
    logic flasher;
    logic digitizer_launch;
    logic fe_ladder_valid;
    logic dig_ladder_valid;
    logic [7:0] ladder_sample;
  } cfs_out_t;
endpackage

// ==== verif/cfs_sequencer_sva.sv ====
// Purpose: port checks for cfs_sequencer
// Assumes: systime is 0 at reset release and counts every clock
// Notes: ctrl is shadowed from port writes, so a missed write shows up here too
`timescale 1ns/1ps
module cfs_sequencer_sva
(
  input wire logic clock,
  input wire logic resetn,
  input cfs_pkg::cfs_req_t req,
  input cfs_pkg::cfs_rsp_t rsp,
  input cfs_pkg::cfs_out_t cal
);
  import cfs_pkg::*;
  logic [47:0] sys_q;
  logic [31:0] ctl_q;
  logic [4:0] off_q;
  logic [8:0] lad_q;
  logic key;
  assign key = req.wr && req.addr == CFS_IDX_CPU && req.wdata[7:0] == CFS_CPU_KEY;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sys_q <= '0;
      ctl_q <= '0;
      off_q <= '0;
      lad_q <= '0;
    end
    else
    begin
      sys_q <= sys_q + 48'h1;
      if (req.wr && req.addr == CFS_IDX_CTRL)
        ctl_q <= req.wdata;
      // off must last past the longest launch lag before silence is demanded
      if (ctl_q[14:12] inside {3'h1, 3'h2, 3'h3})
        off_q <= '0;
      else if (off_q != 5'h1F)
        off_q <= off_q + 5'h1;
      lad_q <= cal.fe_ladder_valid ? lad_q + 9'h1 : '0;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (req.rd |=> rsp.valid) else $error("read not answered");
  a_no_spare_answer: assert property (!req.rd |=> !rsp.valid) else $error("answer without read");
  a_idle_data: assert property (!rsp.valid |-> rsp.data == 32'h00000000) else $error("data off answer");
  a_systime_low: assert property (req.rd && req.addr == CFS_IDX_SYS_LO |=> rsp.data == $past(sys_q[31:0]))
    else $error("systime low wrong");
  a_unmapped_zero: assert property (req.rd && req.addr == 9'h007 |=> rsp.data == 32'h00000000) else $error("unmapped");
  a_cpu_flash: assert property (key && ctl_q[14:12] == CFS_MODE_CPU && ctl_q[1] |-> ##10 cal.pulser)
    else $error("cpu flash missing");
  a_off_silent: assert property (off_q == 5'h1F |-> !(cal.pulser || cal.led || cal.flasher || cal.digitizer_launch))
    else $error("fired while off");
  a_ladder_length: assert property ($fell(cal.fe_ladder_valid) |-> lad_q == 9'h100)
    else $error("ladder length");
  a_ladder_idle: assert property (!cal.fe_ladder_valid && !cal.dig_ladder_valid |-> cal.ladder_sample == 8'h00)
    else $error("sample off stream");
endmodule
bind cfs_sequencer cfs_sequencer_sva cfs_sequencer_sva_i (.clock(clock), .resetn(resetn), .req(req), .rsp(rsp), .cal(cal));

// ==== verif/cfs_sequencer_tb_top.sv ====
// Purpose: self-checking bench for cfs_sequencer
// Assumes: flash 10 cycles after the event edge, stamp 2 before flash
// Notes: timing is measured on a bench copy of systime
`timescale 1ns/1ps
module cfs_sequencer_tb_top;
  import cfs_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  cfs_req_t req = '0;
  cfs_rsp_t rsp;
  cfs_out_t cal;
  int num_errors = 0;
  int checks = 0;
  int seed = 32'h8AB4;
  int cyc = 0;
  int np = 0;
  int nl = 0;
  int k = 0;
  int n0;
  logic [47:0] sys = '0;
  logic [47:0] w_t;
  logic [47:0] p_t;
  logic [47:0] l_t;
  logic [7:0] pat [256];
  logic [31:0] d;
  logic [31:0] v;
  logic [3:0] o;
  cfs_sequencer cfs_sequencer_i (.clock(clock), .resetn(resetn), .req(req), .rsp(rsp), .cal(cal));
  always #50 clock = ~clock;
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [5:0] en, input logic [3:0] of);
    return {12'h000, of, 1'b0, m, 6'h00, en};
  endfunction
  task automatic wr(input logic [8:0] a, input logic [31:0] x);
    @(posedge clock);
    req <= '{1'b1, 1'b0, a, x};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge clock);
    req <= '{1'b0, 1'b1, a, 32'h00000000};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    d = rsp.data;
    chk("valid", 48'h1, rsp.valid);
  endtask
  task automatic fire(input logic [2:0] m, input logic [5:0] en, input logic [3:0] of, input logic [7:0] ky);
    wr(CFS_IDX_CTRL, ctl(m, en, of));
    n0 = np;
    v = $random(seed);
    wr(CFS_IDX_CPU, {v[31:8], ky});
    repeat (24) @(posedge clock);
  endtask
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sys <= '0;
    else
      sys <= sys + 48'h1;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (req.wr && req.addr == CFS_IDX_CPU)
      w_t <= sys;
    if (cal.pulser)
      np <= np + 1;
    if (cal.pulser)
      p_t <= sys;
    if (cal.digitizer_launch)
      nl <= nl + 1;
    if (cal.digitizer_launch)
      l_t <= sys;
    if (cal.pulser | cal.led | cal.flasher)
      chk("together", {3{cal.pulser}}, {cal.pulser, cal.led, cal.flasher});
    if (cal.fe_ladder_valid)
      chk("sample", {1'b1, pat[k[7:0]]}, {cal.dig_ladder_valid, cal.ladder_sample});
    if (cal.fe_ladder_valid)
      k <= k + 1;
    if (cyc > 9000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd(CFS_IDX_CTRL);
    chk("ctrl_reset", CFS_CTRL_RESET, d);
    rd(9'h007);
    chk("unmapped", 48'h0, d);
    rd(CFS_IDX_SYS_HI);
    chk("sys_high", 48'h0, d);
    // enables kept clear so random settings cannot fire
    repeat (4)
    begin
      v = $random(seed) & 32'h0FFFFFC0;
      wr(CFS_IDX_CTRL, v);
      rd(CFS_IDX_CTRL);
      chk("ctrl", v & CFS_CTRL_MASK, d);
    end
    for (int i = 0; i < 3; i++)
    begin
      fire(3'(i * 3 + (i > 0)), 6'h0E, 4'h0, CFS_CPU_KEY);
      chk("off", n0, np);
    end
    fire(CFS_MODE_CPU, 6'h0E, 4'h0, 8'h5A);
    chk("bad_key", n0, np);
    for (int i = 0; i < 3; i++)
    begin
      o = i == 0 ? 4'h8 : i == 1 ? 4'h7 : 4'($random(seed));
      fire(CFS_MODE_CPU, 6'h0E, o, CFS_CPU_KEY);
      chk("flash", w_t + 48'hA, p_t);
      chk("launch", w_t + 48'hA + {{44{o[3]}}, o}, l_t);
      rd(CFS_IDX_LAST_LO);
      chk("last_lo", w_t[31:0] + 32'h8, d);
      rd(CFS_IDX_LAST_HI);
      chk("last_hi", 48'h0, d);
    end
    wr(CFS_IDX_LAST_LO, $random(seed));
    rd(CFS_IDX_LAST_LO);
    chk("last_ro", w_t[31:0] + 32'h8, d);
    fire(CFS_MODE_CPU, 6'h01, 4'h0, CFS_CPU_KEY);
    chk("dark_quiet", n0, np);
    chk("dark_launch", w_t + 48'hA, l_t);
    // fire reloads n0 from the pulser count, so the launch count is kept in k
    k = nl;
    fire(CFS_MODE_CPU, 6'h00, 4'h0, CFS_CPU_KEY);
    chk("no_enable", k, nl);
    for (int i = 0; i < 256; i++)
    begin
      pat[i] = 8'($random(seed));
      wr(9'h100 + 9'(i), {24'h000000, pat[i]});
    end
    rd(9'h1A5);
    chk("pattern", pat[8'hA5], d);
    k = 0;
    fire(CFS_MODE_CPU, 6'h30, 4'h0, CFS_CPU_KEY);
    repeat (250) @(posedge clock);
    chk("stream_len", 48'd256, k);
    v = sys[31:0] + 32'h3C;
    wr(CFS_IDX_MATCH, v);
    wr(CFS_IDX_CTRL, ctl(CFS_MODE_OFF, 6'h0E, 4'h0));
    wr(CFS_IDX_CTRL, ctl(CFS_MODE_MATCH, 6'h0E, 4'h0));
    n0 = np;
    repeat (80) @(posedge clock);
    chk("match", {16'h0000, v + 32'hA}, p_t);
    wr(CFS_IDX_MATCH, sys[31:0] + 32'h28);
    repeat (60) @(posedge clock);
    chk("match_once", n0 + 1, np);
    // a second reset mid-run must bring systime and the stamp back to zero
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(CFS_IDX_SYS_LO);
    chk("sys_restart", 48'h1, d);
    rd(CFS_IDX_LAST_LO);
    chk("last_cleared", 48'h0, d);
    wr(CFS_IDX_CTRL, ctl(CFS_MODE_PERIODIC, 6'h0E, 4'h0) | 32'h11000000);
    repeat (30) @(posedge clock);
    n0 = np;
    repeat (2048) @(posedge clock);
    chk("periodic", n0 + 2, np);
    chk("phase", 48'h200, (p_t - 48'hA) & 48'h3FF);
    print_verdict();
  end
endmodule
